// ===== verilog/dbc_regs.sv
// Debug comparator B low, comparator C and trace FIFO readout registers
// Operation
// - Comparator B low byte matches address bits 7..0, data bits in Full mode.
// - Comparator bit 0 needs a low bus bit, bit 1 a high one.
// - Comparator C high byte sets expected address bits 15..8.
// - Comparator C low byte sets address bits 7..0; C never compares data.
// - End-trace reset with enable set and begin clear keeps all register contents.
// - FIFO high readout shows bits 15..8 of the entry at the read pointer.
// - In event-only modes FIFO high readout returns zero for valid entries.
// - Comparator B high byte is ignored in Full mode.
// - Reading FIFO low advances the pointer; software reads high byte first.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module dbc_regs (
    input wire logic pclk, // Bus clock, 125 MHz
    input wire logic presetn, // Power-on reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction, 1 = write
    input wire logic [dbc_pkg::ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic sys_reset, // One-cycle system reset event
    input wire dbc_pkg::dbc_core_bus_t core, // CPU address and data bus
    input wire dbc_pkg::dbc_mode_t mode, // Debug enable, begin, capture modes
    input wire logic [7:0] comparator_b_high_byte, // Held outside
    input wire dbc_pkg::dbc_fifo_t fifo, // FIFO entry at read pointer
    output logic match_b, // Comparator B hit, registered
    output logic match_c, // Comparator C hit, registered
    output logic fifo_advance // One-cycle pointer advance request
);

    // =====================================================================
    // State
    // =====================================================================
    dbc_pkg::dbc_state_t s_q;
    dbc_pkg::dbc_state_t s_d;

    logic setup;
    logic access;
    logic wr_access;
    logic rd_access;
    logic mapped;
    logic retain;
    logic [31:0] rd_mux;
    logic [7:0] obs_b_low;
    logic hit_b_low;
    logic hit_b_high;
    logic hit_c;
    logic [7:0] view_high;
    logic [7:0] view_low;

    // =====================================================================
    // Comparators
    // =====================================================================
    // Full mode steers comparator B onto the data bus
    assign obs_b_low = mode.full_mode ? core.data : core.addr[7:0];

    dbc_match #(.W(8)) u_match_b_low (
        .expect_bits(s_q.comparator_b_low_byte),
        .observe_bits(obs_b_low),
        .hit(hit_b_low)
    );

    dbc_match #(.W(8)) u_match_b_high (
        .expect_bits(comparator_b_high_byte),
        .observe_bits(core.addr[15:8]),
        .hit(hit_b_high)
    );

    // Comparator C always looks at the address bus
    dbc_match #(.W(16)) u_match_c (
        .expect_bits({s_q.comparator_c_high_byte, s_q.comparator_c_low_byte}),
        .observe_bits(core.addr),
        .hit(hit_c)
    );

    dbc_fifo_view u_fifo_view (
        .fifo(fifo),
        .event_only(mode.event_only),
        .high_byte(view_high),
        .low_byte(view_low)
    );

    // =====================================================================
    // APB decode
    // =====================================================================
    assign setup = psel && !penable;
    assign pready = (s_q.phase == dbc_pkg::DBC_ACCESS);
    assign access = psel && penable && pready;
    assign wr_access = access && pwrite;
    assign rd_access = access && !pwrite;

    always_comb
    begin
        mapped = 1'b1;
        rd_mux = dbc_pkg::RDATA_NONE;
        case (paddr)
            dbc_pkg::ADDR_CMP_B_LOW: rd_mux[7:0] = s_q.comparator_b_low_byte;
            dbc_pkg::ADDR_CMP_C_HIGH: rd_mux[7:0] = s_q.comparator_c_high_byte;
            dbc_pkg::ADDR_CMP_C_LOW: rd_mux[7:0] = s_q.comparator_c_low_byte;
            dbc_pkg::ADDR_FIFO_HIGH: rd_mux[7:0] = view_high;
            dbc_pkg::ADDR_FIFO_LOW: rd_mux[7:0] = view_low;
            default: mapped = 1'b0;
        endcase
    end

    assign pslverr = pready && !mapped;

    // Debug enable with begin clear marks a trace that ends at reset
    assign retain = mode.debug_module_enable && !mode.trig_begin;

    // =====================================================================
    // Next state
    // =====================================================================
    always_comb
    begin
        s_d = s_q;
        s_d.fifo_advance = 1'b0;
        // Matches are quiet while the debug module is off
        s_d.match_b = mode.debug_module_enable && hit_b_low
                      && (mode.full_mode || hit_b_high);
        s_d.match_c = mode.debug_module_enable && hit_c;
        case (s_q.phase)
            dbc_pkg::DBC_IDLE:
            begin
                // Read data is latched in the setup cycle so prdata is a flop
                if (setup)
                begin
                    s_d.phase = dbc_pkg::DBC_ACCESS;
                    s_d.prdata = rd_mux;
                end
            end
            dbc_pkg::DBC_ACCESS:
            begin
                s_d.phase = dbc_pkg::DBC_IDLE;
                if (wr_access)
                begin
                    case (paddr)
                        dbc_pkg::ADDR_CMP_B_LOW: s_d.comparator_b_low_byte = pwdata[7:0];
                        dbc_pkg::ADDR_CMP_C_HIGH: s_d.comparator_c_high_byte = pwdata[7:0];
                        dbc_pkg::ADDR_CMP_C_LOW: s_d.comparator_c_low_byte = pwdata[7:0];
                        // FIFO readouts take no write
                        default: s_d.phase = dbc_pkg::DBC_IDLE;
                    endcase
                end
                if (rd_access && (paddr == dbc_pkg::ADDR_FIFO_LOW))
                begin
                    s_d.fifo_advance = 1'b1;
                end
            end
            default: s_d.phase = dbc_pkg::DBC_IDLE;
        endcase
        // System reset outranks a write in the same cycle unless retained
        if (sys_reset && !retain)
        begin
            s_d.comparator_b_low_byte = dbc_pkg::RST_CMP_B_LOW;
            s_d.comparator_c_high_byte = dbc_pkg::RST_CMP_C_HIGH;
            s_d.comparator_c_low_byte = dbc_pkg::RST_CMP_C_LOW;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '{phase: dbc_pkg::DBC_IDLE,
                     comparator_b_low_byte: dbc_pkg::RST_CMP_B_LOW,
                     comparator_c_high_byte: dbc_pkg::RST_CMP_C_HIGH,
                     comparator_c_low_byte: dbc_pkg::RST_CMP_C_LOW,
                     prdata: dbc_pkg::RDATA_NONE,
                     match_b: 1'b0,
                     match_c: 1'b0,
                     fifo_advance: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign match_b = s_q.match_b;
    assign match_c = s_q.match_c;
    assign fifo_advance = s_q.fifo_advance;

    // =====================================================================
    // Assertions
    // =====================================================================
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_b_full_data;
        mode.debug_module_enable && mode.full_mode && (core.data == s_q.comparator_b_low_byte)
        |=> match_b;
    endproperty
    a_b_full_data: assert property (p_b_full_data)
        else $error("comparator B missed a data match in Full mode");

    property p_zero_bit_low;
        core.addr[0] && !s_q.comparator_c_low_byte[0] |=> !match_c;
    endproperty
    a_zero_bit_low: assert property (p_zero_bit_low)
        else $error("comparator C matched a high bit against a 0");

    property p_c_high_mismatch;
        (core.addr[15:8] != s_q.comparator_c_high_byte) |=> !match_c;
    endproperty
    a_c_high_mismatch: assert property (p_c_high_mismatch)
        else $error("comparator C matched with high address byte differing");

    property p_c_addr_only;
        mode.debug_module_enable && mode.full_mode
        && (core.addr == {s_q.comparator_c_high_byte, s_q.comparator_c_low_byte})
        |=> match_c;
    endproperty
    a_c_addr_only: assert property (p_c_addr_only)
        else $error("comparator C did not match its address in Full mode");

    property p_retain;
        sys_reset && retain && !wr_access
        |=> $stable(s_q.comparator_b_low_byte) && $stable(s_q.comparator_c_high_byte)
            && $stable(s_q.comparator_c_low_byte);
    endproperty
    a_retain: assert property (p_retain)
        else $error("registers changed on a retaining end-trace reset");

    property p_fifo_high;
        setup && pready == 1'b0 && !pwrite && (paddr == dbc_pkg::ADDR_FIFO_HIGH)
        && !(mode.event_only && fifo.valid)
        ##1 rd_access |-> prdata == {24'h00_0000, $past(fifo.entry[15:8])};
    endproperty
    a_fifo_high: assert property (p_fifo_high)
        else $error("FIFO high readout differs from entry bits 15..8");

    property p_fifo_high_event;
        setup && !pready && !pwrite && (paddr == dbc_pkg::ADDR_FIFO_HIGH)
        && mode.event_only && fifo.valid
        |=> prdata == dbc_pkg::RDATA_NONE;
    endproperty
    a_fifo_high_event: assert property (p_fifo_high_event)
        else $error("FIFO high readout not zero in event-only mode");

    property p_b_high_ignored;
        mode.debug_module_enable && mode.full_mode
        && (core.data == s_q.comparator_b_low_byte)
        && (core.addr[15:8] != comparator_b_high_byte)
        |=> match_b;
    endproperty
    a_b_high_ignored: assert property (p_b_high_ignored)
        else $error("comparator B high byte blocked a Full mode match");

    property p_advance;
        rd_access && (paddr == dbc_pkg::ADDR_FIFO_LOW) |=> fifo_advance ##1 !fifo_advance;
    endproperty
    a_advance: assert property (p_advance)
        else $error("FIFO low read did not give a single advance pulse");

    property p_high_write_ignored;
        wr_access && (paddr == dbc_pkg::ADDR_FIFO_HIGH) && !sys_reset
        |=> !fifo_advance && $stable(s_q.comparator_b_low_byte)
            && $stable(s_q.comparator_c_high_byte) && $stable(s_q.comparator_c_low_byte);
    endproperty
    a_high_write_ignored: assert property (p_high_write_ignored)
        else $error("write to FIFO high readout disturbed state");

    // A reset outside a retained trace must leave every byte at its reset value
    property p_reset_clears;
        sys_reset && !retain
        |=> (s_q.comparator_b_low_byte == dbc_pkg::RST_CMP_B_LOW)
            && (s_q.comparator_c_high_byte == dbc_pkg::RST_CMP_C_HIGH)
            && (s_q.comparator_c_low_byte == dbc_pkg::RST_CMP_C_LOW);
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("end-trace reset without retain left a register set");

    property p_cov_full_match;
        mode.full_mode ##1 match_b;
    endproperty
    c_cov_full_match: cover property (p_cov_full_match);

    property p_cov_fifo_pop;
        rd_access && (paddr == dbc_pkg::ADDR_FIFO_LOW) ##1 fifo_advance;
    endproperty
    c_cov_fifo_pop: cover property (p_cov_fifo_pop);

    property p_cov_retain;
        sys_reset && retain;
    endproperty
    c_cov_retain: cover property (p_cov_retain);

    property p_cov_c_match;
        mode.debug_module_enable ##1 match_c;
    endproperty
    c_cov_c_match: cover property (p_cov_c_match);

    property p_cov_event_high;
        rd_access && (paddr == dbc_pkg::ADDR_FIFO_HIGH) && mode.event_only && fifo.valid;
    endproperty
    c_cov_event_high: cover property (p_cov_event_high);

endmodule : dbc_regs

`default_nettype wire

// ===== verilog/dbc_pkg.sv
// Package for the debug comparator B/C and trace FIFO readout registers
package dbc_pkg;

    localparam int unsigned ADDR_W = 6;

    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_CMP_B_LOW = 4'h3;
    localparam logic [3:0] IDX_CMP_C_HIGH = 4'h4;
    localparam logic [3:0] IDX_CMP_C_LOW = 4'h5;
    localparam logic [3:0] IDX_FIFO_HIGH = 4'h6;
    localparam logic [3:0] IDX_FIFO_LOW = 4'h7;

    localparam logic [ADDR_W-1:0] ADDR_CMP_B_LOW = {IDX_CMP_B_LOW, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CMP_C_HIGH = {IDX_CMP_C_HIGH, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_CMP_C_LOW = {IDX_CMP_C_LOW, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_FIFO_HIGH = {IDX_FIFO_HIGH, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_FIFO_LOW = {IDX_FIFO_LOW, 2'b00};

    localparam logic [7:0] RST_CMP_B_LOW = 8'h00;
    localparam logic [7:0] RST_CMP_C_HIGH = 8'h00;
    localparam logic [7:0] RST_CMP_C_LOW = 8'h00;
    localparam logic [7:0] FIFO_EVENT_ONLY_HIGH = 8'h00;
    localparam logic [31:0] RDATA_NONE = 32'h0000_0000;

    typedef enum logic [1:0] {
        DBC_IDLE = 2'b00,
        DBC_ACCESS = 2'b01
    } dbc_phase_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
    } dbc_core_bus_t;

    typedef struct packed {
        logic debug_module_enable;
        logic trig_begin;
        logic full_mode;
        logic event_only;
    } dbc_mode_t;

    typedef struct packed {
        logic [15:0] entry;
        logic valid;
    } dbc_fifo_t;

    typedef struct packed {
        dbc_phase_t phase;
        logic [7:0] comparator_b_low_byte;
        logic [7:0] comparator_c_high_byte;
        logic [7:0] comparator_c_low_byte;
        logic [31:0] prdata;
        logic match_b;
        logic match_c;
        logic fifo_advance;
    } dbc_state_t;

endpackage : dbc_pkg

// ===== verilog/dbc_match.sv
// Bitwise compare of an expected pattern against an observed bus slice
`timescale 1ns/1ps
`default_nettype none

module dbc_match #(
    parameter int unsigned W = 8
) (
    input wire logic [W-1:0] expect_bits, // Expected level per bit
    input wire logic [W-1:0] observe_bits, // Bus bits under test
    output logic hit // All bits equal
);

    logic [W-1:0] bit_eq;

    // A 0 demands a low bus bit, a 1 demands a high one
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        assign bit_eq[i] = ~(expect_bits[i] ^ observe_bits[i]);
    end

    assign hit = &bit_eq;

endmodule : dbc_match

`default_nettype wire

// ===== verilog/dbc_fifo_view.sv
// Readout view of the trace FIFO entry at the read pointer
`timescale 1ns/1ps
`default_nettype none

module dbc_fifo_view (
    input wire dbc_pkg::dbc_fifo_t fifo, // Entry at read pointer
    input wire logic event_only, // Event-only capture mode
    output logic [7:0] high_byte, // Readout of bits 15..8
    output logic [7:0] low_byte // Readout of bits 7..0
);

    // High byte carries nothing for valid entries in event-only modes
    assign high_byte = (event_only && fifo.valid) ? dbc_pkg::FIFO_EVENT_ONLY_HIGH
                                                  : fifo.entry[15:8];
    assign low_byte = fifo.entry[7:0];

endmodule : dbc_fifo_view

`default_nettype wire

// ===== tb/dbc_cpu_model.sv
// Model of the CPU core bus and the trace FIFO entry at the read pointer
`timescale 1ns/1ps
`default_nettype none

module dbc_cpu_model #(
    parameter int DEPTH = 4
) (
    input wire logic pclk, // Bus clock
    input wire logic presetn, // Reset, active low
    input wire logic fifo_advance, // Pointer advance request
    output var dbc_pkg::dbc_core_bus_t core, // CPU address and data bus
    output var dbc_pkg::dbc_fifo_t fifo // Entry at read pointer
);
    logic [2:0] ptr_q;

    initial core = '0;

    // ====================================
    // Read pointer, moved only by the block
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ptr_q <= 3'h0;
        else if (fifo_advance && ptr_q < DEPTH)
            ptr_q <= ptr_q + 3'h1;
    end

    // Entries follow a fixed pattern so the bench can predict them
    assign fifo.valid = ptr_q < DEPTH;
    assign fifo.entry = 16'h9A60 + 16'(ptr_q) * 16'h1111;

    // ====================================
    // Bus cycle, launched right after an edge
    task put_bus(input logic [15:0] a, input logic [7:0] d);
        @(posedge pclk);
        core <= {a, d};
    endtask : put_bus
endmodule : dbc_cpu_model
`default_nettype wire

// ===== tb/dbc_regs_test.sv
// Self-checking bench for the comparator and FIFO readout registers
`timescale 1ns/1ps
`default_nettype none

`define CHK(act, exp) \
    begin \
        n_compared++; \
        if ((act) !== (exp)) \
        begin \
            fail_count++; \
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (act), (exp)); \
        end \
    end

module dbc_regs_test;
    logic pclk, presetn, psel, penable, pwrite, sys_reset, pready, pslverr, er;
    logic match_b, match_c, fifo_advance;
    logic [5:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] b_high;
    dbc_pkg::dbc_core_bus_t core;
    dbc_pkg::dbc_mode_t mode;
    dbc_pkg::dbc_fifo_t fifo;
    int fail_count = 0;
    int n_compared = 0;
    logic [5:0] regs [3] = '{dbc_pkg::ADDR_CMP_B_LOW, dbc_pkg::ADDR_CMP_C_HIGH, dbc_pkg::ADDR_CMP_C_LOW};
    logic [7:0] vals [3] = '{8'h34, 8'h56, 8'h78};
    // Same fixed pattern as the model's FIFO entries
    logic [15:0] ents [4] = '{16'h9A60, 16'hAB71, 16'hBC82, 16'hCD93};
    int n_adv = 0;

    dbc_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sys_reset(sys_reset), .core(core), .mode(mode), .comparator_b_high_byte(b_high),
        .fifo(fifo), .match_b(match_b), .match_c(match_c), .fifo_advance(fifo_advance));

    dbc_cpu_model i_cpu (.pclk(pclk), .presetn(presetn), .fifo_advance(fifo_advance), .core(core), .fifo(fifo));

    // Counts pointer advance pulses seen by the far side
    always @(posedge pclk)
        if (fifo_advance === 1'b1)
            n_adv++;

    // ====================================
    // Clock, reset and watchdog
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    initial
    begin
        #100000;
        fail_count++;
        final_report();
    end

    // ====================================
    // Access tasks
    task apb(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Request holds until pready is seen high at an edge; only the watchdog ends this wait
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        // Data and error are taken at that same edge, before the release
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd_chk(input logic [5:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rd, {24'h00_0000, exp})
    endtask : rd_chk

    task bus_chk(input logic [15:0] a, input logic [7:0] d, input logic eb, input logic ec);
        i_cpu.put_bus(a, d);
        @(posedge pclk);
        #1;
        `CHK(match_b, eb)
        `CHK(match_c, ec)
    endtask : bus_chk

    task set_mode(input logic [3:0] m);
        @(posedge pclk);
        mode <= m;
    endtask : set_mode

    task pulse_reset();
        @(posedge pclk);
        sys_reset <= 1'b1;
        @(posedge pclk);
        sys_reset <= 1'b0;
    endtask : pulse_reset

    task final_report();
        $display("compared %0d, mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    // ====================================
    // Tests
    initial
    begin
        {psel, penable, pwrite, sys_reset} = 4'h0;
        paddr = '0;
        pwdata = '0;
        mode = '0;
        b_high = 8'h12;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (regs[i]) rd_chk(regs[i], 8'h00);
        $display("test reset values done");

        foreach (regs[i]) apb(1'b1, regs[i], {24'hFF_FFFF, vals[i]});
        foreach (regs[i]) rd_chk(regs[i], vals[i]);
        apb(1'b1, 6'h00, 32'h0000_00FF);
        `CHK(er, 1'b1)
        rd_chk(6'h00, 8'h00);
        `CHK(er, 1'b1)
        apb(1'b1, dbc_pkg::ADDR_FIFO_HIGH, 32'h0000_00FF);
        `CHK(er, 1'b0)
        rd_chk(dbc_pkg::ADDR_FIFO_HIGH, ents[0][15:8]);
        $display("test register access done");

        set_mode(4'b1000);
        bus_chk(16'h1234, 8'h00, 1'b1, 1'b0);
        bus_chk(16'h5678, 8'h00, 1'b0, 1'b1);
        for (int i = 0; i < 16; i++)
            bus_chk(16'h5678 ^ (16'h0001 << i), 8'h00, 1'b0, 1'b0);
        set_mode(4'b1010);
        bus_chk(16'h5678, 8'h34, 1'b1, 1'b1);
        bus_chk(16'h1234, 8'h35, 1'b0, 1'b0);
        // Data equal to C's low byte must not stand in for the address
        bus_chk(16'h5600, 8'h78, 1'b0, 1'b0);
        set_mode(4'b0000);
        bus_chk(16'h5678, 8'h34, 1'b0, 1'b0);
        $display("test comparators done");

        set_mode(4'b1000);
        rd_chk(dbc_pkg::ADDR_FIFO_HIGH, ents[0][15:8]);
        rd_chk(dbc_pkg::ADDR_FIFO_LOW, ents[0][7:0]);
        rd_chk(dbc_pkg::ADDR_FIFO_HIGH, ents[1][15:8]);
        set_mode(4'b1001);
        rd_chk(dbc_pkg::ADDR_FIFO_HIGH, 8'h00);
        rd_chk(dbc_pkg::ADDR_FIFO_LOW, ents[1][7:0]);
        // The advance pulse follows the access edge; let it be counted
        repeat (2) @(posedge pclk);
        `CHK(n_adv, 2)
        $display("test fifo readout done");

        set_mode(4'b1000);
        pulse_reset();
        foreach (regs[i]) rd_chk(regs[i], vals[i]);
        set_mode(4'b1100);
        pulse_reset();
        foreach (regs[i]) rd_chk(regs[i], 8'h00);
        $display("test end-trace reset done");
        final_report();
    end
endmodule : dbc_regs_test
`default_nettype wire
